/* common/cmcp_pkg.sv */
// Package: constants for the configuration-mode command parser
package cmcp_pkg;
  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_RSSI = 8'h53;
  localparam logic [7:0] CMD_TEMP = 8'h55;
  localparam logic [7:0] CMD_VOLT = 8'h56;
  localparam logic [7:0] CMD_CFG_WRITE = 8'h4d;
  localparam logic [7:0] CMD_EXIT = 8'h58;
  localparam logic [7:0] CMD_SLEEP_PIN = 8'h5a;
  localparam logic [7:0] CMD_SLEEP_RXD = 8'h7a;
  localparam logic [7:0] CMD_KEY_LOAD = 8'h4b;
  localparam logic [7:0] KEY_INDEX = 8'h37;
  localparam logic [7:0] CMD_CAL_PREFIX = 8'h48;
  localparam logic [7:0] CMD_CAL_SECOND = 8'h57;
  localparam logic [7:0] WRITE_TERM = 8'hff;
  localparam logic [7:0] PROMPT = 8'h3e;
  // ==========================================================
  // Encodings
  localparam logic [7:0] TEMP_BIAS = 8'h80;
  localparam int TEMP_TRIM_STEPS_PER_DEG = 4;
  localparam int VOLT_STEP_MV = 30;
  // ==========================================================
  // Memory map
  localparam logic [7:0] CAL_ADDR_THERMAL_TRIM = 8'h00;
  localparam logic [7:0] CFG_ADDR_CHANNEL = 8'h00;
  localparam logic [7:0] THERMAL_TRIM_RESET = 8'h80;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam int KEY_BYTES = 16;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int KEY_TIMEOUT_S = 10;
  localparam longint KEY_TIMEOUT_CYC = longint'(KEY_TIMEOUT_S) * CLK_HZ;
  localparam int COMMIT_WAIT_CYC = 1000;
endpackage : cmcp_pkg

/* common/cmcp_nvm_if.sv */
// Interface: write port from the parser to the memory store
`timescale 1ns/1ps
interface cmcp_nvm_if;
  logic we;
  logic sel_cal;
  logic sel_key;
  logic [7:0] addr;
  logic [7:0] data;
  logic [7:0] trim;
  logic [7:0] channel;
  modport parser (output we, output sel_cal, output sel_key, output addr,
    output data, input trim, input channel);
  modport store (input we, input sel_cal, input sel_key, input addr,
    input data, output trim, output channel);
endinterface : cmcp_nvm_if

/* src/cmcp_store.sv */
// Separate configuration, calibration and key stores
`timescale 1ns/1ps
module cmcp_store
  import cmcp_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic factory_reset,
  cmcp_nvm_if.store nvm
);
  logic [7:0] cfg_mem [DEPTH];
  logic [7:0] cal_mem [DEPTH];
  // Write-only: nothing reads it back to any port
  logic [7:0] key_mem [KEY_BYTES];
  logic [7:0] trim_q;
  logic [7:0] channel_q;
  wire cfg_hit = nvm.we && !nvm.sel_cal && !nvm.sel_key;
  wire cal_hit = nvm.we && nvm.sel_cal && !nvm.sel_key;

  always_ff @(posedge sys_clk) begin
    if (cfg_hit) begin
      cfg_mem[nvm.addr[6:0]] <= nvm.data;
    end
    if (cal_hit) begin
      cal_mem[nvm.addr[6:0]] <= nvm.data;
    end
    if (nvm.we && nvm.sel_key) begin
      key_mem[nvm.addr[3:0]] <= nvm.data;
    end
  end

  // Factory reset restores only the channel register; config memory, calibration and key stay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trim_q <= THERMAL_TRIM_RESET;
      channel_q <= CHANNEL_RESET;
    end else begin
      if (factory_reset) begin
        channel_q <= CHANNEL_RESET;
      end else if (cfg_hit && nvm.addr == CFG_ADDR_CHANNEL) begin
        channel_q <= nvm.data;
      end
      if (cal_hit && nvm.addr == CAL_ADDR_THERMAL_TRIM) begin
        trim_q <= nvm.data;
      end
    end
  end
  assign nvm.trim = trim_q;
  assign nvm.channel = channel_q;
endmodule : cmcp_store

/* src/cmcp_parser.sv */
// Configuration-mode command interpreter
`timescale 1ns/1ps
module cmcp_parser
  import cmcp_pkg::*;
#(
  parameter longint KEY_TIMEOUT = KEY_TIMEOUT_CYC,
  parameter int COMMIT_WAIT = COMMIT_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic setup_pin,
  input wire logic rxd_pin,
  input wire logic remote_config,
  input wire logic factory_reset,
  input wire logic [7:0] signal_level,
  input wire logic [9:0] temp_quarter_raw,
  input wire logic [15:0] supply_mv,
  output logic config_active,
  output logic sleeping,
  output logic pullup_en,
  output logic restart_req,
  output logic [7:0] event_temp,
  output logic [7:0] event_supply,
  output logic [7:0] channel_out
);
  typedef enum {
    S_RUN, S_CMD, S_HW2, S_KIDX, S_ADDR, S_DATA, S_COMMIT, S_KEY,
    S_TX_VAL, S_TX_PROMPT, S_SLEEP_PIN, S_SLEEP_RXD, S_EXIT
  } cmcp_state_t;

  cmcp_state_t state_q, state_d;
  cmcp_nvm_if nvm ();

  // ==========================================================
  // Pin synchronisers
  logic [1:0] setup_sync_q, rxd_sync_q;
  logic setup_prev_q, rxd_prev_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      setup_sync_q <= 2'b00;
      rxd_sync_q <= 2'b11;
      setup_prev_q <= 1'b0;
      rxd_prev_q <= 1'b1;
    end else begin
      setup_sync_q <= {setup_sync_q[0], setup_pin};
      rxd_sync_q <= {rxd_sync_q[0], rxd_pin};
      setup_prev_q <= setup_sync_q[1];
      rxd_prev_q <= rxd_sync_q[1];
    end
  end
  wire setup_lvl = setup_sync_q[1];
  wire setup_fall = setup_prev_q && !setup_lvl;
  wire rxd_fall = rxd_prev_q && !rxd_sync_q[1];

  // ==========================================================
  // Sensor encodings
  // Trim of 0x80 is neutral; each count is 0.25 C
  logic [11:0] temp_corr;
  logic [7:0] temp_code, volt_code;
  logic [15:0] volt_div;
  assign temp_corr = {2'b00, temp_quarter_raw} + {4'h0, nvm.trim}
    - {4'h0, THERMAL_TRIM_RESET};
  // Quarter degrees above -128 C, converted to whole degrees
  assign temp_code = temp_corr[9:2];
  assign volt_div = supply_mv / 16'(VOLT_STEP_MV);
  assign volt_code = (volt_div > 16'h00ff) ? 8'hff : volt_div[7:0];

  // ==========================================================
  // Counters
  logic [63:0] key_tmr_q;
  logic [31:0] commit_q;
  logic [4:0] key_cnt_q;
  logic [7:0] addr_q, resp_q;
  logic sel_cal_q, we_q, sel_key_q;
  logic [7:0] wr_addr_q, wr_data_q;
  wire key_timeout = key_tmr_q >= 64'(KEY_TIMEOUT);
  wire commit_done = commit_q >= 32'(COMMIT_WAIT - 1);
  wire tx_free = !tx_valid || tx_ready;
  // A lone follow-up byte must not open a pair write or a key load
  wire bad_lead = (state_q == S_CMD) &&
    (rx_data inside {CMD_CAL_SECOND, KEY_INDEX});

  // ==========================================================
  // Command decode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_RUN: begin
        if (setup_fall || remote_config) begin
          state_d = S_TX_PROMPT;
        end
      end
      S_CMD: begin
        if (rx_valid) begin
          unique case (rx_data)
            CMD_RSSI, CMD_TEMP, CMD_VOLT: state_d = S_TX_VAL;
            CMD_CFG_WRITE: state_d = S_TX_PROMPT;
            CMD_CAL_PREFIX: state_d = S_HW2;
            CMD_KEY_LOAD: state_d = S_KIDX;
            CMD_EXIT: state_d = S_EXIT;
            CMD_SLEEP_PIN: begin
              state_d = setup_lvl ? S_TX_PROMPT : S_SLEEP_PIN;
            end
            CMD_SLEEP_RXD: state_d = S_SLEEP_RXD;
            default: state_d = S_TX_PROMPT;
          endcase
        end
      end
      S_HW2, S_KIDX: begin
        if (rx_valid) begin
          state_d = S_TX_PROMPT;
        end
      end
      S_ADDR: begin
        if (rx_valid) begin
          state_d = (rx_data == WRITE_TERM) ? S_COMMIT : S_DATA;
        end
      end
      S_DATA: begin
        if (rx_valid) begin
          state_d = S_ADDR;
        end
      end
      S_COMMIT: begin
        if (commit_done) begin
          state_d = S_TX_PROMPT;
        end
      end
      S_KEY: begin
        if (key_timeout) begin
          state_d = S_CMD;
        end else if (rx_valid && key_cnt_q == 5'(KEY_BYTES - 1)) begin
          state_d = S_TX_PROMPT;
        end
      end
      S_TX_VAL: begin
        if (tx_free) begin
          state_d = S_TX_PROMPT;
        end
      end
      S_TX_PROMPT: begin
        if (tx_free) begin
          unique case (resp_q)
            CMD_CFG_WRITE, CMD_CAL_SECOND: state_d = S_ADDR;
            KEY_INDEX: state_d = S_KEY;
            default: state_d = S_CMD;
          endcase
        end
      end
      S_SLEEP_PIN: begin
        if (setup_lvl) begin
          state_d = S_CMD;
        end
      end
      S_SLEEP_RXD: begin
        if (rxd_fall) begin
          state_d = S_CMD;
        end
      end
      S_EXIT: state_d = S_RUN;
    endcase
  end

  // ==========================================================
  // Sequencing state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_RUN;
      resp_q <= 8'h00;
      sel_cal_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == S_RUN) begin
        resp_q <= 8'h00;
      end else if (rx_valid && state_q inside {S_CMD, S_HW2, S_KIDX}) begin
        // Bad second byte falls back to a plain prompt
        resp_q <= (state_q == S_HW2 && rx_data != CMD_CAL_SECOND) ||
          (state_q == S_KIDX && rx_data != KEY_INDEX) || bad_lead ? 8'h00 :
          rx_data;
      end else if (state_q == S_TX_PROMPT && tx_free) begin
        resp_q <= 8'h00;
      end
      if (rx_valid && state_q == S_CMD) begin
        sel_cal_q <= (rx_data == CMD_CAL_PREFIX);
      end
      if (rx_valid && state_q == S_ADDR) begin
        addr_q <= rx_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_q != S_COMMIT) begin
      commit_q <= 32'h0000_0000;
    end else begin
      commit_q <= commit_q + 32'h0000_0001;
    end
  end

  // Gap timer restarts on every key byte
  always_ff @(posedge sys_clk) begin
    if (rst || state_q != S_KEY || rx_valid) begin
      key_tmr_q <= 64'h0;
    end else begin
      key_tmr_q <= key_tmr_q + 64'h1;
    end
    if (rst || state_q != S_KEY) begin
      key_cnt_q <= 5'h00;
    end else if (rx_valid) begin
      key_cnt_q <= key_cnt_q + 5'h01;
    end
  end

  // ==========================================================
  // Memory write port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      we_q <= 1'b0;
      sel_key_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      we_q <= rx_valid && !key_timeout &&
        (state_q == S_DATA || state_q == S_KEY);
      sel_key_q <= (state_q == S_KEY);
      wr_addr_q <= (state_q == S_KEY) ? {3'h0, key_cnt_q} : addr_q;
      wr_data_q <= rx_data;
    end
  end
  assign nvm.we = we_q;
  assign nvm.sel_cal = sel_cal_q;
  assign nvm.sel_key = sel_key_q;
  assign nvm.addr = wr_addr_q;
  assign nvm.data = wr_data_q;

  cmcp_store u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .factory_reset(factory_reset),
    .nvm(nvm)
  );

  // ==========================================================
  // Response bytes; the key store has no path here
  logic [7:0] value_byte;
  assign value_byte = (resp_q == CMD_RSSI) ? signal_level :
    (resp_q == CMD_TEMP) ? temp_code : volt_code;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      config_active <= 1'b0;
      sleeping <= 1'b0;
      pullup_en <= 1'b1;
      restart_req <= 1'b0;
      event_temp <= TEMP_BIAS;
      event_supply <= 8'h00;
      channel_out <= CHANNEL_RESET;
    end else begin
      if (tx_free) begin
        tx_valid <= state_q inside {S_TX_VAL, S_TX_PROMPT};
        tx_data <= (state_q == S_TX_VAL) ? value_byte : PROMPT;
      end
      config_active <= !(state_d inside {S_RUN, S_EXIT});
      sleeping <= state_d inside {S_SLEEP_PIN, S_SLEEP_RXD};
      pullup_en <= !(state_d inside {S_SLEEP_PIN, S_SLEEP_RXD});
      restart_req <= (state_q == S_EXIT);
      event_temp <= temp_code;
      event_supply <= volt_code;
      channel_out <= nvm.channel;
    end
  end
endmodule : cmcp_parser

/* verif/cmcp_monitor.sv */
// Checker: timing relations at the parser ports
`timescale 1ns/1ps
module cmcp_monitor
  import cmcp_pkg::*;
#(
  parameter longint KEY_TIMEOUT = KEY_TIMEOUT_CYC,
  parameter int COMMIT_WAIT = COMMIT_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] signal_level,
  input wire logic [15:0] supply_mv,
  input wire logic config_active,
  input wire logic sleeping,
  input wire logic pullup_en,
  input wire logic restart_req,
  input wire logic [7:0] event_temp,
  input wire logic [7:0] event_supply
);
  // ==========================================================
  // Helpers
  wire take = rx_valid && config_active && !tx_valid;
  wire [15:0] sup_div = supply_mv / 16'(VOLT_STEP_MV);
  wire [7:0] sup_code = (sup_div > 16'h00ff) ? 8'hff : sup_div[7:0];
  logic [15:0] ff_cnt_q;
  logic ff_wait_q;
  always_ff @(posedge sys_clk) begin
    if (rst || tx_valid) ff_wait_q <= 1'b0;
    else if (take && rx_data == WRITE_TERM) ff_wait_q <= 1'b1;
    if (take && rx_data == WRITE_TERM) ff_cnt_q <= 16'h0000;
    else if (ff_cnt_q != 16'hffff) ff_cnt_q <= ff_cnt_q + 16'h0001;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tx_byte_stands: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("tx byte moved early");
  a_temp_answer: assert property (take && rx_data == CMD_TEMP |->
    ##2 tx_valid && tx_data == event_temp) else $error("bad temp reply");
  a_level_answer: assert property (take && rx_data == CMD_RSSI |->
    ##2 tx_valid && tx_data == signal_level) else $error("bad level");
  a_prompt_follows: assert property (tx_valid && tx_ready &&
    tx_data != PROMPT |=> ##[0:2] tx_valid && tx_data == PROMPT)
    else $error("no prompt after value");
  a_supply_code: assert property ($stable(supply_mv) [*3] |->
    event_supply == sup_code) else $error("bad supply code");
  a_sleep_pullup: assert property (sleeping && $past(sleeping) |->
    !pullup_en) else $error("pull-ups on in sleep");
  a_restart_once: assert property (restart_req |=> !restart_req)
    else $error("restart longer than a cycle");
  a_exit_restart: assert property (take && rx_data == CMD_EXIT |->
    ##[1:3] restart_req) else $error("no restart after exit");
  a_commit_wait: assert property (tx_valid && ff_wait_q |->
    ff_cnt_q >= COMMIT_WAIT - 1) else $error("prompt before commit");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !tx_valid
    && !config_active && pullup_en && !restart_req)
    else $error("outputs not idle after reset");
  c_exit: cover property (restart_req);
  c_sleep: cover property ($fell(sleeping));
  c_commit: cover property (tx_valid && ff_wait_q);
endmodule : cmcp_monitor

bind cmcp_parser cmcp_monitor #(.KEY_TIMEOUT(KEY_TIMEOUT),
  .COMMIT_WAIT(COMMIT_WAIT)) u_mon (.*);

/* verif/cmcp_host_model.sv */
// Host model: UART byte source and reply sink
`timescale 1ns/1ps
module cmcp_host_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] got[$];
  logic [1:0] gap_q = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Slow mode stalls the transmitter three cycles in four
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    gap_q <= gap_q + 2'h1;
    tx_ready <= #1 (!slow || gap_q == 2'h0);
  end
  // Raw bytes; caller waits for each prompt before a new command
  task automatic send(logic [7:0] b);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask : send
endmodule : cmcp_host_model

/* verif/tb_config_mode_command_parser.sv */
// Testbench: command sequences through the host model
`timescale 1ns/1ps
module tb_config_mode_command_parser;
  import cmcp_pkg::*;
  localparam int CW = 20;
  localparam int KT = 200;
  logic sys_clk, rst, setup_pin, rxd_pin, remote_config, factory_reset;
  logic slow;
  logic [7:0] signal_level;
  logic [9:0] temp_quarter_raw;
  logic [15:0] supply_mv;
  wire rx_valid, tx_ready, tx_valid, config_active, sleeping;
  wire pullup_en, restart_req;
  wire [7:0] rx_data, tx_data, event_temp, event_supply, channel_out;
  logic [7:0] q_cmd [3];
  logic [7:0] q_exp [3];
  int err_total = 0;
  int cmp_count = 0;

  cmcp_host_model u_host (.sys_clk(sys_clk), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));
  cmcp_parser #(.KEY_TIMEOUT(KT), .COMMIT_WAIT(CW)) DUT (
    .sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .setup_pin(setup_pin), .rxd_pin(rxd_pin),
    .remote_config(remote_config), .factory_reset(factory_reset),
    .signal_level(signal_level), .temp_quarter_raw(temp_quarter_raw),
    .supply_mv(supply_mv), .config_active(config_active),
    .sleeping(sleeping), .pullup_en(pullup_en), .restart_req(restart_req),
    .event_temp(event_temp), .event_supply(event_supply),
    .channel_out(channel_out));

  // ==========================================================
  // Tasks
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // Bounded wait for the next byte from the parser
  task automatic get(logic [7:0] exp, string what);
    int n;
    n = 0;
    while (u_host.got.size() == 0 && n < 300) begin
      cyc(1);
      n++;
    end
    check(what, (u_host.got.size() > 0) ? u_host.got.pop_front() : 8'hxx,
      exp);
  endtask : get
  task automatic quiet(string what);
    check(what, 8'(u_host.got.size()), 8'h00);
  endtask : quiet
  task automatic enter();
    setup_pin = 1'b1;
    cyc(6);
    setup_pin = 1'b0;
    get(PROMPT, "entry prompt");
    check("config_active", {7'h0, config_active}, 8'h01);
  endtask : enter
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #(40 * 20000);
    err_total++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    setup_pin = 1'b0;
    rxd_pin = 1'b1;
    remote_config = 1'b0;
    factory_reset = 1'b0;
    slow = 1'b0;
    signal_level = 8'h5a;
    temp_quarter_raw = 10'h260;
    supply_mv = 16'h0c30;
    q_cmd = '{CMD_RSSI, CMD_TEMP, CMD_VOLT};
    q_exp = '{8'h5a, 8'h98, 8'h68};
    cyc(12);
    rst = 1'b0;
    cyc(1);
    check("pullup_en", {7'h0, pullup_en}, 8'h01);
    enter();
    for (int i = 0; i < 3; i++) begin
      u_host.send(q_cmd[i]);
      get(q_exp[i], "query value");
      get(PROMPT, "query prompt");
    end
    check("event_temp", event_temp, 8'h98);
    check("event_supply", event_supply, 8'h68);
    u_host.send(8'h41);
    get(PROMPT, "unknown prompt");
    u_host.send(CMD_CAL_SECOND);
    get(PROMPT, "lone second byte");
    u_host.send(CMD_KEY_LOAD);
    u_host.send(8'h41);
    get(PROMPT, "bad key index");
    u_host.send(CMD_CAL_PREFIX);
    u_host.send(8'h41);
    get(PROMPT, "bad cal second");
    $display("Test queries finished");
    u_host.send(CMD_CFG_WRITE);
    get(PROMPT, "write prompt");
    u_host.send(CFG_ADDR_CHANNEL);
    u_host.send(8'h03);
    cyc(5);
    quiet("pairs silent");
    u_host.send(WRITE_TERM);
    cyc(CW - 3);
    quiet("commit silent");
    get(PROMPT, "commit prompt");
    check("channel_out", channel_out, 8'h03);
    slow = 1'b1;
    u_host.send(CMD_CAL_PREFIX);
    u_host.send(CMD_CAL_SECOND);
    get(PROMPT, "cal prompt");
    u_host.send(CAL_ADDR_THERMAL_TRIM);
    u_host.send(8'h78);
    u_host.send(WRITE_TERM);
    get(PROMPT, "cal commit");
    u_host.send(CMD_TEMP);
    get(8'h96, "trimmed temp");
    get(PROMPT, "temp prompt");
    slow = 1'b0;
    $display("Test memory writes finished");
    u_host.send(CMD_KEY_LOAD);
    u_host.send(KEY_INDEX);
    get(PROMPT, "key prompt");
    for (int i = 0; i < KEY_BYTES; i++) u_host.send(8'h10 + 8'(i));
    get(PROMPT, "key done");
    check("channel kept", channel_out, 8'h03);
    u_host.send(CMD_KEY_LOAD);
    u_host.send(KEY_INDEX);
    get(PROMPT, "key prompt 2");
    repeat (3) u_host.send(8'h21);
    cyc(KT + 20);
    u_host.send(CMD_VOLT);
    get(8'h68, "after timeout");
    get(PROMPT, "volt prompt");
    factory_reset = 1'b1;
    cyc(1);
    factory_reset = 1'b0;
    cyc(3);
    check("factory channel", channel_out, CHANNEL_RESET);
    u_host.send(CMD_EXIT);
    cyc(1);
    check("restart_req", {7'h0, restart_req}, 8'h01);
    cyc(3);
    check("exit", {7'h0, config_active}, 8'h00);
    quiet("exit silent");
    $display("Test key and exit finished");
    remote_config = 1'b1;
    cyc(1);
    remote_config = 1'b0;
    get(PROMPT, "remote prompt");
    u_host.send(CMD_SLEEP_RXD);
    cyc(14);
    check("rxd sleep", {7'h0, sleeping}, 8'h01);
    check("pullup off", {7'h0, pullup_en}, 8'h00);
    rxd_pin = 1'b0;
    cyc(6);
    check("rxd wake", {7'h0, sleeping}, 8'h00);
    rxd_pin = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    enter();
    setup_pin = 1'b1;
    cyc(5);
    u_host.send(CMD_SLEEP_PIN);
    get(PROMPT, "sleep refused");
    check("no sleep", {7'h0, sleeping}, 8'h00);
    setup_pin = 1'b0;
    cyc(5);
    u_host.send(CMD_SLEEP_PIN);
    cyc(4);
    check("pin sleep", {7'h0, sleeping}, 8'h01);
    setup_pin = 1'b1;
    cyc(6);
    check("pin wake", {7'h0, sleeping}, 8'h00);
    check("pullup back", {7'h0, pullup_en}, 8'h01);
    $display("Test sleep finished");
    close_out();
  end
endmodule : tb_config_mode_command_parser
